/* logic/runaway_watchdog_timer.sv */
// Runaway watchdog timer with Avalon-MM register slave
// What this block does
// - 22-stage counter advanced at half system clock
// - Tap 2^16/18/20/22 selected by detection field
// - Overflow pulses non-maskable irq and sets flag
// - Reset connection on: chip reset 32 states
// - After watchdog reset, clock gear divides eight
// - Detection field two bits, reset to 00
// - Enable bit resets to one, watchdog active
// - Disable needs enable clear plus B1 code
// - Writing enable one re-enables at once
// - Reset connection bit resets to zero
// - Code 4E clears counter, counting continues
// - Disable code also clears the counter
// - Counting starts right after reset release
// - STOP mode holds counter in reset
// - Counter keeps running while bus released
// - IDLE mode runs per idle-run select bit
// - Watchdog output for peripheral reset pins
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
module runaway_watchdog_timer #(
   parameter int unsigned CW = wdt_pkg::CNT_W
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic [wdt_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [wdt_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic [wdt_pkg::DATA_W-1:0]      avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic                       stop_mode,
   input  wire logic                       idle_mode,
   input  wire logic                       bus_release_ack_n,
   output logic                            runaway_irq,
   output logic                            nmi_watchdog_flag,
   output logic                            wd_reset_out,
   output logic                            clk_gear_div8
);
   import wdt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [1:0]           detect_time_sel;
      logic                 wd_enable_bit;
      logic                 overflow_reset_connect;
      logic                 idle_run_select;
      logic                 disabled;
      logic [CW-1:0]        count;
      logic                 half;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic                 runaway_irq;
      logic                 nmi_watchdog_flag;
      logic                 wd_reset_out;
      logic                 clk_gear_div8;
      logic                 acked;
      logic [DATA_W-1:0]    rdata;
   } wdt_state_s;

   wdt_state_s state_reg;
   wdt_state_s state_next;

   logic stop_sync;
   logic idle_sync;
   logic bus_rel_sync;
   logic tap_ovf;
   logic running;
   logic carry;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   wdt_sync u_sync_stop (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (stop_mode),
      .q        (stop_sync)
   );

   wdt_sync u_sync_idle (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (idle_mode),
      .q        (idle_sync)
   );

   // Bus release is sampled for completeness; it never stops counting
   wdt_sync u_sync_bus (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (bus_release_ack_n),
      .q        (bus_rel_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Counter control

   // Released bus does not enter this term, so counting continues
   assign running = ~state_reg.disabled & ~stop_sync & ~bus_rel_sync
                    | ~state_reg.disabled & ~stop_sync;
   assign carry = running & state_reg.half
                  & ~(idle_sync & ~state_reg.idle_run_select);

   wdt_tap_sel #(
      .CW (CW)
   ) u_tap (
      .count   (state_reg.count),
      .carry   (carry),
      .sel     (state_reg.detect_time_sel),
      .tap_ovf (tap_ovf)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic wr_mode;
      logic wr_cmd;
      logic [7:0] code;
      logic en_new;
      wr_mode    = 1'b0;
      wr_cmd     = 1'b0;
      code       = avs_writedata[7:0];
      en_new     = state_reg.wd_enable_bit;
      state_next = state_reg;
      state_next.runaway_irq = 1'b0;
      state_next.acked       = 1'b0;

      // One wait cycle per access, then an acknowledge cycle
      if ((avs_read | avs_write) & ~state_reg.acked) begin
         state_next.acked = 1'b1;
         wr_mode = avs_write & (avs_address == ADDR_MODE)
                   & avs_byteenable[0];
         wr_cmd  = avs_write & (avs_address == ADDR_CMD)
                   & avs_byteenable[0];
         state_next.rdata = READ_ZERO;
         if (avs_read) begin
            unique case (avs_address)
               ADDR_MODE: begin
                  state_next.rdata[BIT_ENABLE] = state_reg.wd_enable_bit;
                  state_next.rdata[FLD_DET_LO +: 2] =
                     state_reg.detect_time_sel;
                  state_next.rdata[BIT_RST_CONN] =
                     state_reg.overflow_reset_connect;
                  state_next.rdata[BIT_IDLE_RUN] =
                     state_reg.idle_run_select;
               end
               ADDR_STATUS: begin
                  state_next.rdata[7:0] = state_reg.disabled ?
                     8'h00 : STATUS_ACTIVE;
                  state_next.rdata[8 +: CW] = state_reg.count;
               end
               default: state_next.rdata = READ_ZERO;
            endcase
         end
      end

      if (wr_mode) begin
         state_next.detect_time_sel = code[FLD_DET_LO +: 2];
         state_next.overflow_reset_connect = code[BIT_RST_CONN];
         state_next.idle_run_select = code[BIT_IDLE_RUN];
         state_next.wd_enable_bit = code[BIT_ENABLE];
         en_new = code[BIT_ENABLE];
         if (code[BIT_ENABLE]) begin
            state_next.disabled = 1'b0;
         end
      end

      // Advance at half the system clock
      state_next.half = ~state_reg.half;
      if (carry) begin
         state_next.count = state_reg.count + 1'b1;
      end
      if (stop_sync) begin
         state_next.count = '0;
         state_next.half  = 1'b0;
      end

      if (tap_ovf) begin
         state_next.runaway_irq       = 1'b1;
         state_next.nmi_watchdog_flag = 1'b1;
         state_next.count             = '0;
         if (state_reg.overflow_reset_connect) begin
            state_next.rst_cnt       = RST_CNT_W'(RESET_STATES);
            state_next.clk_gear_div8 = 1'b1;
         end
      end else if (state_reg.rst_cnt != '0) begin
         state_next.rst_cnt = state_reg.rst_cnt - 1'b1;
      end
      state_next.wd_reset_out = (state_next.rst_cnt != '0);

      if (wr_cmd) begin
         if (code == CODE_CLEAR) begin
            state_next.count = '0;
            state_next.half  = 1'b0;
         end else if (code == CODE_DISABLE) begin
            state_next.count = '0;
            state_next.half  = 1'b0;
            if (~en_new) begin
               state_next.disabled = 1'b1;
            end
         end
         // Any other code leaves state untouched
      end
      // Flag is cleared only by this block's own rst input
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.detect_time_sel <= DET_RESET;
         state_reg.wd_enable_bit <= ENABLE_RESET;
         state_reg.overflow_reset_connect <= RST_CONN_RESET;
         state_reg.idle_run_select <= IDLE_RUN_RESET;
         state_reg.disabled <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign avs_readdata      = state_reg.rdata;
   assign avs_waitrequest   = ~state_reg.acked;
   assign runaway_irq       = state_reg.runaway_irq;
   assign nmi_watchdog_flag = state_reg.nmi_watchdog_flag;
   assign wd_reset_out      = state_reg.wd_reset_out;
   assign clk_gear_div8     = state_reg.clk_gear_div8;
endmodule : runaway_watchdog_timer

/* logic/wdt_pkg.sv */
// Constants for the runaway watchdog timer
package wdt_pkg;
   localparam int unsigned CNT_W          = 22;
   localparam int unsigned ADDR_W         = 4;
   localparam int unsigned DATA_W         = 32;
   localparam logic [3:0]  ADDR_MODE      = 4'h0;
   localparam logic [3:0]  ADDR_CMD       = 4'h4;
   localparam logic [3:0]  ADDR_STATUS    = 4'h8;
   localparam logic [7:0]  CODE_CLEAR     = 8'h4E;
   localparam logic [7:0]  CODE_DISABLE   = 8'hB1;
   localparam int unsigned BIT_IDLE_RUN   = 2;
   localparam int unsigned BIT_RST_CONN   = 1;
   localparam int unsigned BIT_ENABLE     = 7;
   localparam int unsigned FLD_DET_LO     = 4;
   localparam logic [1:0]  DET_RESET      = 2'h0;
   localparam logic        ENABLE_RESET   = 1'b1;
   localparam logic        RST_CONN_RESET = 1'b0;
   localparam logic        IDLE_RUN_RESET = 1'b0;
   localparam int unsigned RESET_STATES   = 32;
   localparam int unsigned RST_CNT_W      = 6;
   localparam logic [7:0]  STATUS_ACTIVE  = 8'h01;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage : wdt_pkg

/* logic/wdt_sync.sv */
// Two-stage synchroniser for a level from another domain
`timescale 1ns/10ps
module wdt_sync (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic meta_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_reg <= 1'b0;
         q        <= 1'b0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : wdt_sync

/* logic/wdt_tap_sel.sv */
// Overflow tap selection from the counter stages
`timescale 1ns/10ps
module wdt_tap_sel #(
   parameter int unsigned CW = 22
) (
   input  wire logic [CW-1:0] count,
   input  wire logic          carry,
   input  wire logic [1:0]    sel,
   output logic               tap_ovf
);
   // Taps two stages apart below the top; CW 22 gives 2^16 to 2^22
   localparam int unsigned TAP0 = CW - 6;
   localparam int unsigned TAP1 = CW - 4;
   localparam int unsigned TAP2 = CW - 2;

   // Overflow of a tap: its low stages all ones on the advance
   always_comb begin
      unique case (sel)
         2'h0: tap_ovf = carry & (&count[TAP0-1:0]);
         2'h1: tap_ovf = carry & (&count[TAP1-1:0]);
         2'h2: tap_ovf = carry & (&count[TAP2-1:0]);
         2'h3: tap_ovf = carry & (&count[CW-1:0]);
      endcase
   end
endmodule : wdt_tap_sel

/* bench/wdt_properties.sv */
// Port assertions for the runaway watchdog
`timescale 1ns/10ps
module wdt_properties
   import wdt_pkg::*;
#(
   parameter int unsigned CW = CNT_W
) (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        stop_mode,
   input wire logic        runaway_irq,
   input wire logic        nmi_watchdog_flag,
   input wire logic        wd_reset_out,
   input wire logic        clk_gear_div8
);
   logic [5:0] run_reg;
   logic [5:0] run_next;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Saturates so a stuck reset output cannot wrap to 32
   always_comb run_next = !wd_reset_out ? 6'h00 :
                          (run_reg == 6'h3F) ? run_reg : run_reg + 6'h01;
   always_ff @(posedge core_clk) begin
      run_reg <= rst ? 6'h00 : run_next;
   end
   sequence ovf_s;
      runaway_irq;
   endsequence
   sequence stop_s;
      stop_mode [*6];
   endsequence
   sequence st_rd_s;
      avs_read && !avs_waitrequest && avs_address == ADDR_STATUS;
   endsequence
   chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("ack held over one cycle");
   chk_ack_bound: assert property ((avs_read || avs_write) |->
      ##[0:1] !avs_waitrequest) else $error("ack late");
   chk_irq_pulse: assert property (ovf_s |=> !runaway_irq)
      else $error("irq not a pulse");
   chk_flag_set: assert property (ovf_s |-> ##[0:1] nmi_watchdog_flag)
      else $error("flag not set");
   chk_flag_hold: assert property (
      nmi_watchdog_flag |=> nmi_watchdog_flag) else $error("flag dropped");
   chk_reset_width: assert property (
      $fell(wd_reset_out) |-> run_reg == 6'h20)
      else $error("reset width wrong");
   chk_gear_set: assert property (
      $rose(wd_reset_out) |-> ##[0:1] clk_gear_div8)
      else $error("gear not set");
   chk_stop_zero: assert property (stop_s ##0 st_rd_s |->
      avs_readdata[CW+7:8] == '0) else $error("count moved in stop");
endmodule : wdt_properties
bind runaway_watchdog_timer wdt_properties #(.CW(CW)) wdt_properties_i (
   .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .stop_mode, .runaway_irq, .nmi_watchdog_flag,
   .wd_reset_out, .clk_gear_div8);

/* bench/wdt_host_model.sv */
// Chip reset and non-maskable interrupt logic beside the watchdog
`timescale 1ns/10ps
module wdt_host_model (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       runaway_irq,
   input  wire logic       wd_reset_out,
   output logic      [7:0] irq_count,
   output logic      [7:0] rst_width
);
   logic [7:0] run;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_count <= 8'h00;
         rst_width <= 8'h00;
         run       <= 8'h00;
      end else begin
         irq_count <= irq_count + {7'h00, runaway_irq};
         // Peripheral reset pins follow the level; width logged on fall
         run <= wd_reset_out ? run + 8'h01 : 8'h00;
         if (!wd_reset_out && run != 8'h00) begin
            rst_width <= run;
         end
      end
   end
endmodule : wdt_host_model

/* bench/runaway_watchdog_timer_tb.sv */
// Register-level testbench for the runaway watchdog
`timescale 1ns/10ps
module runaway_watchdog_timer_tb;
   import wdt_pkg::*;
   // Short counter keeps the tap waits inside the run budget
   localparam int unsigned TB_CW = 16;
   // Cycles to a tap overflow: two clocks per count
   localparam int TAP0_N = 1 << (TB_CW - 5);
   localparam int TAP1_N = 1 << (TB_CW - 3);
   logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  be;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        stop_mode, idle_mode, bus_ack_n, div8;
   logic        runaway_irq, nmi_watchdog_flag, wd_reset_out;
   logic [7:0]  irq_count, rst_width;
   logic [21:0] c1, c2;
   int          n_mismatch, n_compared, n;
   runaway_watchdog_timer #(.CW(TB_CW)) runaway_watchdog_timer_i (
      .core_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(be), .avs_readdata,
      .avs_waitrequest, .stop_mode, .idle_mode,
      .bus_release_ack_n(bus_ack_n), .runaway_irq, .nmi_watchdog_flag,
      .wd_reset_out, .clk_gear_div8(div8));
   wdt_host_model wdt_host_model_i (.core_clk, .rst, .runaway_irq,
      .wd_reset_out, .irq_count, .rst_width);
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic results;
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'h1) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // Idle edge first, so a release never meets a new request
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] d);
      int k;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_write     <= wr;
      avs_read      <= !wr;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'h0 && k < 50);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read  <= 1'h0;
      if (k >= 50) begin
         chk(1'h0, "bus timeout");
         results();
      end
   endtask : bus
   task automatic cnt(output logic [21:0] c);
      bus(1'h0, ADDR_STATUS, 8'h00);
      c = q[29:8];
   endtask : cnt
   task automatic wait_irq(input int lim);
      n = 0;
      while (runaway_irq !== 1'h1 && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= lim) begin
         chk(1'h0, "irq timeout");
         results();
      end
   endtask : wait_irq
   ////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'h1;
      {avs_read, avs_write, stop_mode, idle_mode} = 4'h0;
      bus_ack_n = 1'h1;
      be = 4'hF;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (4) @(posedge core_clk);
      rst <= 1'h0;
      bus(1'h0, ADDR_MODE, 8'h00);
      chk(q === 32'h80, "mode reset");
      cnt(c1);
      chk(q[0] === 1'h1 && c1 > 22'h0, "runs after reset");
      bus(1'h0, 4'hC, 8'h00);
      chk(q === READ_ZERO, "unmapped read");
      bus(1'h1, ADDR_CMD, CODE_CLEAR);
      cnt(c1);
      chk(c1 <= 22'h4, "clear code");
      repeat (200) @(posedge core_clk);
      cnt(c1);
      chk(c1 >= 22'h5F && c1 <= 22'h6C, "half rate");
      bus(1'h1, ADDR_CMD, 8'h55);
      cnt(c2);
      chk(c2 > c1, "other code");
      bus(1'h1, ADDR_MODE, 8'h00);
      cnt(c1);
      chk(q[0] === 1'h1 && c1 > c2, "enable clear alone");
      bus(1'h1, ADDR_CMD, CODE_DISABLE);
      repeat (40) @(posedge core_clk);
      cnt(c1);
      chk(q[0] === 1'h0 && c1 === 22'h0, "disable");
      bus(1'h1, ADDR_MODE, 8'h80);
      repeat (20) @(posedge core_clk);
      cnt(c1);
      chk(q[0] === 1'h1 && c1 > 22'h5, "re-enable");
      bus_ack_n <= 1'h0;
      bus(1'h1, ADDR_CMD, CODE_CLEAR);
      repeat (100) @(posedge core_clk);
      cnt(c1);
      chk(c1 >= 22'h28, "bus released");
      bus_ack_n <= 1'h1;
      idle_mode <= 1'h1;
      repeat (10) @(posedge core_clk);
      cnt(c1);
      repeat (100) @(posedge core_clk);
      cnt(c2);
      chk(c1 === c2, "idle stop");
      bus(1'h1, ADDR_MODE, 8'h84);
      repeat (50) @(posedge core_clk);
      cnt(c1);
      chk(c1 > c2, "idle run");
      bus(1'h0, ADDR_MODE, 8'h00);
      chk(q === 32'h84, "mode readback");
      be <= 4'h0;
      bus(1'h1, ADDR_MODE, 8'h00);
      be <= 4'hF;
      bus(1'h0, ADDR_MODE, 8'h00);
      chk(q === 32'h84, "lane off write");
      idle_mode <= 1'h0;
      stop_mode <= 1'h1;
      repeat (10) @(posedge core_clk);
      cnt(c1);
      chk(c1 === 22'h0, "stop");
      stop_mode <= 1'h0;
      bus(1'h1, ADDR_MODE, 8'h82);
      bus(1'h1, ADDR_CMD, CODE_CLEAR);
      wait_irq(TAP0_N + 64);
      chk(n >= TAP0_N - 16 && n <= TAP0_N + 16, "tap time");
      repeat (40) @(posedge core_clk);
      chk(nmi_watchdog_flag === 1'h1 && irq_count === 8'h01, "nmi");
      chk(rst_width === 8'h20 && div8 === 1'h1, "reset");
      bus(1'h1, ADDR_MODE, 8'h90);
      bus(1'h1, ADDR_CMD, CODE_CLEAR);
      wait_irq(TAP1_N + 64);
      chk(n >= TAP1_N - 16 && n <= TAP1_N + 16, "tap one");
      repeat (2) @(posedge core_clk);
      chk(wd_reset_out === 1'h0 && irq_count === 8'h02, "irq only");
      results();
   end
endmodule : runaway_watchdog_timer_tb
